// ---- src/evsm_pkg.sv ----
// Purpose: constants and functions shared by the excitation and stability monitor
// Assumes: one drive sample clock of 25 MHz; registers reached by plain register port
// Notes:
// Summary of operation
// - the binary sequence restarts every two to the power of the length exponent, divided by the gap, drive samples.
// - the length exponent only has effect while the mode selects binary excitation.
// - with velocity injection the velocity amplitude is the peak value of the injected excitation.
// - in stability-test mode the feedback velocity is compared with the fault threshold at all times.
// - while feedback velocity is above the threshold in that mode, an elapsed-time counter advances.
// - when the elapsed time reaches a nonzero duration limit the instability fault is raised; a zero limit never trips.
// - the duration limit is counted in time units of milliseconds and is applied only in mode five.
// - mode one is binary excitation, at plus or minus peak with velocity injection (zero at other points), varying only in sign.
package evsm_pkg;
  // ***************************************************
  // register map
  // ***************************************************
  localparam logic [15:0] ADDR_PRB_EXP = 16'h0032;
  localparam logic [15:0] ADDR_VEL_AMP = 16'h0034;
  localparam logic [15:0] ADDR_VF_LIMIT = 16'h0514;
  localparam logic [7:0] PRB_EXP_RESET = 8'h13;
  localparam logic [7:0] PRB_EXP_MIN = 8'h04;
  localparam logic [7:0] PRB_EXP_MAX = 8'h13;
  localparam logic [63:0] VEL_AMP_RESET = 64'h0;
  localparam logic [31:0] VF_LIMIT_RESET = 32'h0;
  // ***************************************************
  // modes and timing
  // ***************************************************
  localparam logic [2:0] MODE_PRB = 3'h1;
  localparam logic [2:0] MODE_STABILITY = 3'h5;
  localparam logic [1:0] INJ_VELOCITY = 2'h1;
  localparam int LFSR_W = 19;
  localparam int PERIOD_W = 20;
  localparam int CLK_HZ = 25000000;
  // limit register holds milliseconds: one count is this many ms
  localparam int LIMIT_UNIT_MS = 1;
  localparam int LIMIT_TICK_CYCLES = CLK_HZ / 1000 * LIMIT_UNIT_MS;

  // feedback taps of a maximal-length register, by length 4..19
  function automatic logic [LFSR_W-1:0] taps(input logic [7:0] n);
    logic [LFSR_W-1:0] t;
    t = 19'h0;
    case (n)
      8'h04: t = 19'h0000c;
      8'h05: t = 19'h00014;
      8'h06: t = 19'h00030;
      8'h07: t = 19'h00060;
      8'h08: t = 19'h000b8;
      8'h09: t = 19'h00110;
      8'h0a: t = 19'h00240;
      8'h0b: t = 19'h00500;
      8'h0c: t = 19'h00829;
      8'h0d: t = 19'h0100d;
      8'h0e: t = 19'h02015;
      8'h0f: t = 19'h06000;
      8'h10: t = 19'h0d008;
      8'h11: t = 19'h12000;
      8'h12: t = 19'h20400;
      8'h13: t = 19'h40023;
      default: t = 19'h0000c;
    endcase
    return t;
  endfunction

  // all-ones seed of the active length
  function automatic logic [LFSR_W-1:0] seed(input logic [7:0] n);
    return LFSR_W'((20'h1 << n[4:0]) - 20'h1);
  endfunction
endpackage

// ---- src/evsm_above_timer.sv ----
// Purpose: times feedback velocity above threshold and raises the instability fault
// Assumes: inputs come from logic on the same clock
// Notes: fault is sticky until i_fault_clear; a new set wins over the clear
`timescale 1ns/1ps
module evsm_above_timer #(
  parameter int TICK_CYCLES = evsm_pkg::LIMIT_TICK_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_enable,
  input wire logic i_above,
  input wire logic [31:0] i_limit,
  input wire logic i_fault_clear,
  output logic o_fault,
  output logic [31:0] o_elapsed
);
  // the divider is 24 bits wide, so the tick must fit in it
  if (TICK_CYCLES < 1 || TICK_CYCLES > 16777215) begin : g_tick_check
    $error("tick count out of range");
  end

  typedef struct packed {
    logic [23:0] div;
    logic [31:0] elapsed;
    logic fault;
  } evsm_timer_type;

  evsm_timer_type st;
  evsm_timer_type next_st;
  logic hit;

  assign hit = i_enable && (i_limit != 32'h0) && (st.elapsed >= i_limit);

  // ***************************************************
  // elapsed time and fault
  // ***************************************************
  // counting restarts whenever velocity drops back, so only a continuous excursion faults
  always_comb begin
    next_st = st;
    if (i_enable && i_above) begin
      if (st.div == 24'(TICK_CYCLES - 1)) begin
        next_st.div = 24'h0;
        if (st.elapsed != 32'hffffffff) begin
          next_st.elapsed = st.elapsed + 32'h1;
        end
      end else begin
        next_st.div = st.div + 24'h1;
      end
    end else begin
      next_st.div = 24'h0;
      next_st.elapsed = 32'h0;
    end
    if (i_fault_clear) begin
      next_st.fault = 1'b0;
    end
    if (hit) begin
      next_st.fault = 1'b1;
    end
  end

  // state register
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_fault = st.fault;
  assign o_elapsed = st.elapsed;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  fault_cause_a: assert property ($rose(o_fault) |-> $past(hit)) else $error("fault rose without cause");
  fault_set_a: assert property (hit |=> o_fault) else $error("fault missed at limit");
  elapsed_clear_a: assert property (!(i_enable && i_above) |=> o_elapsed == 32'h0) else $error("elapsed not cleared");
  elapsed_step_a: assert property (o_elapsed != $past(o_elapsed) && o_elapsed != 32'h0
    |-> o_elapsed == $past(o_elapsed) + 32'h1) else $error("elapsed stepped wrongly");
  fault_hold_a: assert property (o_fault && !i_fault_clear |=> o_fault) else $error("fault dropped");
  fault_seen_c: cover property ($rose(o_fault));
endmodule

// ---- src/evsm_top.sv ----
// Purpose: binary excitation generator and stability monitor for a servo drive
// Assumes: sample strobe, mode and feedback come from logic on the same clock
// Notes: register port is a plain single-cycle read/write port
`timescale 1ns/1ps
module evsm_top #(
  parameter int TICK_CYCLES = evsm_pkg::LIMIT_TICK_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [15:0] i_reg_addr,
  input wire logic [63:0] i_reg_wdata,
  output logic [63:0] o_reg_rdata,
  input wire logic i_sample_en,
  input wire logic [2:0] i_excitation_mode,
  input wire logic [7:0] i_excitation_gap,
  input wire logic [1:0] i_injection_point,
  input wire logic signed [63:0] i_feedback_velocity,
  input wire logic signed [63:0] i_velocity_fault_threshold,
  input wire logic i_fault_clear,
  output logic signed [63:0] o_velocity_excitation,
  output logic o_prb_level,
  output logic o_prb_period_start,
  output logic o_instability_fault,
  output logic [31:0] o_above_elapsed
);
  typedef struct packed {
    logic [7:0] prb_length_exponent;
    logic [63:0] velocity_excitation_amplitude;
    logic [31:0] velocity_fault_duration_limit;
    logic [63:0] rdata;
    logic [evsm_pkg::LFSR_W-1:0] lfsr;
    logic [7:0] gap_cnt;
    logic [evsm_pkg::PERIOD_W-1:0] period_cnt;
    logic period_start;
    logic [63:0] excitation;
  } evsm_state_type;

  evsm_state_type st;
  evsm_state_type next_st;
  logic prb_active;
  logic stab_active;
  logic above;
  logic [7:0] gap_eff;
  logic [evsm_pkg::PERIOD_W-1:0] full_len;
  logic [evsm_pkg::PERIOD_W-1:0] period_len;
  logic [evsm_pkg::LFSR_W-1:0] seed_now;
  logic [evsm_pkg::LFSR_W-1:0] mask_now;
  logic tap_parity;
  logic [evsm_pkg::LFSR_W-1:0] lfsr_shift;
  logic [evsm_pkg::LFSR_W-1:0] lfsr_step;

  // ***************************************************
  // mode decode and sequence arithmetic
  // ***************************************************
  assign prb_active = (i_excitation_mode == evsm_pkg::MODE_PRB);
  assign stab_active = (i_excitation_mode == evsm_pkg::MODE_STABILITY);
  assign above = stab_active && (i_feedback_velocity > i_velocity_fault_threshold);
  // a gap of zero would divide by zero, so it acts as one
  assign gap_eff = (i_excitation_gap == 8'h0) ? 8'h1 : i_excitation_gap;
  assign full_len = evsm_pkg::PERIOD_W'(20'h1 << st.prb_length_exponent[4:0]);
  // gaps larger than the length leave a period of one sample
  assign period_len = ((full_len / evsm_pkg::PERIOD_W'(gap_eff)) == 20'h0) ? 20'h1
    : (full_len / evsm_pkg::PERIOD_W'(gap_eff));
  assign seed_now = evsm_pkg::seed(st.prb_length_exponent);
  assign mask_now = evsm_pkg::taps(st.prb_length_exponent);
  assign tap_parity = ^(st.lfsr & mask_now);
  assign lfsr_shift = {st.lfsr[evsm_pkg::LFSR_W-2:0], tap_parity} & seed_now;
  // shortening the exponent mid-run can mask the state to zero, where it would stick; reseed instead
  assign lfsr_step = (lfsr_shift == '0) ? seed_now : lfsr_shift;

  // ***************************************************
  // registers, sequence and excitation
  // ***************************************************
  // exponent writes outside 4..19 are dropped so the shift register always has valid taps
  always_comb begin
    next_st = st;
    next_st.period_start = 1'b0;
    if (i_reg_wr) begin
      case (i_reg_addr)
        evsm_pkg::ADDR_PRB_EXP: begin
          if (i_reg_wdata[7:0] >= evsm_pkg::PRB_EXP_MIN && i_reg_wdata[7:0] <= evsm_pkg::PRB_EXP_MAX) begin
            next_st.prb_length_exponent = i_reg_wdata[7:0];
          end
        end
        evsm_pkg::ADDR_VEL_AMP: next_st.velocity_excitation_amplitude = i_reg_wdata;
        evsm_pkg::ADDR_VF_LIMIT: next_st.velocity_fault_duration_limit = i_reg_wdata[31:0];
        default: next_st.rdata = st.rdata;
      endcase
    end
    if (i_reg_rd) begin
      case (i_reg_addr)
        evsm_pkg::ADDR_PRB_EXP: next_st.rdata = {56'h0, st.prb_length_exponent};
        evsm_pkg::ADDR_VEL_AMP: next_st.rdata = st.velocity_excitation_amplitude;
        evsm_pkg::ADDR_VF_LIMIT: next_st.rdata = {32'h0, st.velocity_fault_duration_limit};
        default: next_st.rdata = 64'h0; // unmapped reads return zero
      endcase
    end
    if (!prb_active) begin
      // outside binary mode the exponent has no effect; hold the sequence at its seed
      next_st.lfsr = seed_now;
      next_st.gap_cnt = 8'h0;
      next_st.period_cnt = '0;
      next_st.excitation = 64'h0;
    end else if (i_sample_en) begin
      if (st.period_cnt >= period_len - 20'h1) begin
        next_st.period_cnt = '0;
        next_st.lfsr = seed_now;
        next_st.gap_cnt = 8'h0;
        next_st.period_start = 1'b1;
      end else begin
        next_st.period_cnt = st.period_cnt + 20'h1;
        if (st.gap_cnt >= gap_eff - 8'h1) begin
          next_st.gap_cnt = 8'h0;
          next_st.lfsr = lfsr_step;
        end else begin
          next_st.gap_cnt = st.gap_cnt + 8'h1;
        end
      end
    end
    if (prb_active) begin
      // only the sign changes: plus or minus peak amplitude
      if (i_injection_point == evsm_pkg::INJ_VELOCITY) begin
        next_st.excitation = st.lfsr[0] ? st.velocity_excitation_amplitude
          : (64'h0 - st.velocity_excitation_amplitude);
      end else begin
        next_st.excitation = 64'h0;
      end
    end
  end

  // state register
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st <= '0;
      st.prb_length_exponent <= evsm_pkg::PRB_EXP_RESET;
      st.velocity_excitation_amplitude <= evsm_pkg::VEL_AMP_RESET;
      st.velocity_fault_duration_limit <= evsm_pkg::VF_LIMIT_RESET;
      st.lfsr <= 19'h7ffff;
    end else begin
      st <= next_st;
    end
  end

  // ***************************************************
  // stability monitor
  // ***************************************************
  evsm_above_timer #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_timer (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_enable(stab_active),
    .i_above(above),
    .i_limit(st.velocity_fault_duration_limit),
    .i_fault_clear(i_fault_clear),
    .o_fault(o_instability_fault),
    .o_elapsed(o_above_elapsed)
  );

  assign o_reg_rdata = st.rdata;
  assign o_velocity_excitation = st.excitation;
  assign o_prb_level = st.lfsr[0];
  assign o_prb_period_start = st.period_start;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  // the seed is the one in force at the restart edge; an exponent write may land on that same edge
  period_seed_a: assert property (o_prb_period_start |-> st.lfsr == $past(seed_now))
    else $error("period did not reseed");
  period_spacing_a: assert property (prb_active && i_sample_en && st.period_cnt == period_len - 20'h1
    |=> o_prb_period_start) else $error("period end missed");
  idle_zero_a: assert property (!prb_active |=> o_velocity_excitation == 64'h0) else $error("excitation outside mode");
  peak_level_a: assert property (prb_active && i_injection_point == evsm_pkg::INJ_VELOCITY
    |=> o_velocity_excitation == ($past(st.lfsr[0]) ? $past(st.velocity_excitation_amplitude)
    : 64'h0 - $past(st.velocity_excitation_amplitude))) else $error("excitation not at peak");
  exp_range_a: assert property (st.prb_length_exponent >= evsm_pkg::PRB_EXP_MIN
    && st.prb_length_exponent <= evsm_pkg::PRB_EXP_MAX) else $error("exponent out of range");
  lfsr_nonzero_a: assert property (st.lfsr != '0) else $error("sequence stuck at zero");
  period_seen_c: cover property (o_prb_period_start);
  negative_peak_c: cover property (prb_active ##1 o_velocity_excitation[63]);
  stab_above_c: cover property (above [*3]);
endmodule

// ---- bench/evsm_servo_model.sv ----
// Purpose: servo loop stand-in giving the sample strobe and the feedback velocity
// Assumes: shares the monitor's clock and reset
// Notes: feedback is the commanded bias plus the injected excitation, one clock late
`timescale 1ns/1ps
module evsm_servo_model (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic signed [63:0] i_bias,
  input wire logic signed [63:0] i_excitation,
  output logic o_sample_en,
  output logic signed [63:0] o_feedback_velocity
);
  // ****************************************
  // sample strobe and loop response
  // ****************************************
  // strobe on every second clock so that samples and clocks differ in count
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_sample_en <= 1'b0;
      o_feedback_velocity <= 64'sh0;
    end else begin
      o_sample_en <= ~o_sample_en;
      o_feedback_velocity <= i_bias + i_excitation; // the loop answers one clock late
    end
  end
endmodule

// ---- bench/evsm_top_tb.sv ----
// Purpose: self-checking bench for the excitation generator and stability monitor
// Assumes: time tick shortened to 4 clocks; a sample strobe on every second clock
// Notes: periods come from 2 to the exponent over the gap, fault times from the tick
`timescale 1ns/1ps
module evsm_top_tb;
  // ****************************************
  // signals and instances
  // ****************************************
  localparam int TICK = 4;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_reg_wr = 1'b0;
  logic i_reg_rd = 1'b0;
  logic [15:0] i_reg_addr = 16'h0000;
  logic [63:0] i_reg_wdata = 64'h0;
  logic [2:0] i_excitation_mode = 3'h0;
  logic [7:0] i_excitation_gap = 8'h01;
  logic [1:0] i_injection_point = 2'h1;
  logic signed [63:0] thr = 64'sh64;
  logic signed [63:0] bias = 64'sh0;
  logic i_fault_clear = 1'b0;
  logic [63:0] o_reg_rdata;
  logic sample_en;
  logic signed [63:0] feedback;
  logic signed [63:0] o_velocity_excitation;
  logic o_prb_level;
  logic o_prb_period_start;
  logic o_instability_fault;
  logic [31:0] o_above_elapsed;
  logic [63:0] rd;
  logic lvl;
  logic [63:0] amp = 64'h100;
  int failures = 0;
  int num_checks = 0;
  int cycles = 0;
  int samples = 0;
  int last_period = 0;
  int n;
  always #20 i_clk = ~i_clk;
  evsm_top #(.TICK_CYCLES(TICK)) i_evsm_top (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
    .i_sample_en(sample_en), .i_excitation_mode(i_excitation_mode), .i_excitation_gap(i_excitation_gap),
    .i_injection_point(i_injection_point), .i_feedback_velocity(feedback), .i_velocity_fault_threshold(thr),
    .i_fault_clear(i_fault_clear), .o_velocity_excitation(o_velocity_excitation), .o_prb_level(o_prb_level),
    .o_prb_period_start(o_prb_period_start), .o_instability_fault(o_instability_fault),
    .o_above_elapsed(o_above_elapsed));
  evsm_servo_model i_evsm_servo_model (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_bias(bias),
    .i_excitation(o_velocity_excitation), .o_sample_en(sample_en), .o_feedback_velocity(feedback));
  // ****************************************
  // tasks
  // ****************************************
  task automatic final_report();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic check_val(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp);
    check_val({63'h0, got}, {63'h0, exp});
  endtask
  task automatic reg_write(input logic [15:0] addr, input logic [63:0] data);
    @(posedge i_clk);
    i_reg_wr <= 1'b1;
    i_reg_addr <= addr;
    i_reg_wdata <= data;
    @(posedge i_clk);
    i_reg_wr <= 1'b0;
  endtask
  // read data is taken just after the edge that accepts the strobe
  task automatic reg_read(input logic [15:0] addr, output logic [63:0] data);
    @(posedge i_clk);
    i_reg_rd <= 1'b1;
    i_reg_addr <= addr;
    @(posedge i_clk);
    i_reg_rd <= 1'b0;
    #1 data = o_reg_rdata;
  endtask
  task automatic idle(input int k);
    repeat (k) @(posedge i_clk);
    #1;
  endtask
  task automatic wait_fault(output int cnt);
    cnt = 0;
    while (o_instability_fault !== 1'b1 && cnt < 40) begin
      @(posedge i_clk);
      #1 cnt++;
    end
  endtask
  // bounded wait for k restarts of the sequence
  task automatic wait_pulses(input int k);
    int guard;
    guard = 0;
    repeat (k) begin
      do begin
        @(posedge i_clk);
        #1 guard++;
      end while (o_prb_period_start !== 1'b1 && guard < 2000);
    end
  endtask
  // samples between restarts; a restart never lands on a strobe clock
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (o_prb_period_start === 1'b1) begin
      last_period <= samples;
      samples <= 0;
    end else if (sample_en === 1'b1) begin
      samples <= samples + 1;
    end
    if (cycles == 20000) begin
      failures++;
      final_report();
    end
  end
  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    repeat (12) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    reg_read(16'h0032, rd);
    check_val(rd, {56'h0, evsm_pkg::PRB_EXP_RESET});
    reg_read(16'h0034, rd);
    check_val(rd, 64'h0);
    reg_read(16'h0514, rd);
    check_val(rd, 64'h0);
    reg_write(16'h0100, 64'h5a);
    reg_read(16'h0100, rd);
    check_val(rd, 64'h0);
    // out-of-range exponents leave the register alone
    for (int i = 0; i < 3; i++) begin
      reg_write(16'h0032, {56'h0, 8'h03 + 8'(i * 17) - 8'(i / 2 * 33)});
      reg_read(16'h0032, rd);
      check_val(rd, (i < 2) ? 64'h13 : 64'h04);
    end
    reg_write(16'h0034, amp);
    reg_read(16'h0034, rd);
    check_val(rd, amp);
    reg_write(16'h0514, 64'hffff_ffff_0000_0002);
    reg_read(16'h0514, rd);
    check_val(rd, 64'h2);
    // period is 2 to the exponent over the gap, counted in samples
    // a gap of zero acts as one
    for (int g = 0; g <= 3; g++) begin
      @(posedge i_clk);
      i_excitation_gap <= 8'(g);
      i_excitation_mode <= 3'h1;
      wait_pulses(3);
      idle(2);
      check_val(64'(last_period), 64'(16 / ((g == 0) ? 1 : g)));
    end
    // excitation follows the sequence level of the clock before
    n = 0;
    idle(1);
    lvl = o_prb_level;
    repeat (40) begin
      idle(1);
      check_val(o_velocity_excitation, lvl ? amp : -amp);
      n += o_prb_level;
      lvl = o_prb_level;
    end
    check_bit(n > 0 && n < 40, 1'b1);
    @(posedge i_clk);
    i_excitation_gap <= 8'h01;
    reg_write(16'h0032, 64'h5);
    wait_pulses(3);
    idle(2);
    check_val(64'(last_period), 64'd32);
    @(posedge i_clk);
    i_excitation_mode <= 3'h0;
    idle(80);
    check_val(o_velocity_excitation, 64'h0);
    check_bit(samples >= 36, 1'b1);
    // stability test: equal is not above, then one above crossing
    @(posedge i_clk);
    i_excitation_mode <= 3'h5;
    i_injection_point <= 2'h0;
    bias <= 64'sh64;
    idle(30);
    check_bit(o_instability_fault, 1'b0);
    check_val({32'h0, o_above_elapsed}, 64'h0);
    @(posedge i_clk);
    bias <= 64'sh65;
    wait_fault(n);
    check_bit(n >= 9 && n <= 11, 1'b1);
    check_val({32'h0, o_above_elapsed}, 64'h2);
    @(posedge i_clk);
    bias <= 64'sh0;
    idle(4);
    check_bit(o_instability_fault, 1'b1);
    check_val({32'h0, o_above_elapsed}, 64'h0);
    @(posedge i_clk);
    i_fault_clear <= 1'b1;
    @(posedge i_clk);
    i_fault_clear <= 1'b0;
    idle(2);
    check_bit(o_instability_fault, 1'b0);
    // far above the threshold but outside the stability mode
    @(posedge i_clk);
    i_excitation_mode <= 3'h1;
    bias <= 64'sh3e8;
    idle(30);
    check_bit(o_instability_fault, 1'b0);
    check_val({32'h0, o_above_elapsed}, 64'h0);
    check_val(o_velocity_excitation, 64'h0);
    // negative threshold needs a signed compare; limit of one tick
    reg_write(16'h0514, 64'h1);
    @(posedge i_clk);
    i_excitation_mode <= 3'h5;
    thr <= -64'sh0a;
    bias <= 64'sh05;
    wait_fault(n);
    check_bit(n >= 5 && n <= 7, 1'b1);
    // a zero limit never trips, even while above
    reg_write(16'h0514, 64'h0);
    @(posedge i_clk);
    i_fault_clear <= 1'b1;
    @(posedge i_clk);
    i_fault_clear <= 1'b0;
    idle(30);
    check_bit(o_instability_fault, 1'b0);
    final_report();
  end
endmodule
